// ---- design/ufm_endpoint_fifo_manager.sv ----
// Purpose: endpoint buffer manager, ten 64-byte buffers on five endpoints
// Assumes: cpu and engine run on sys_clk_in; cpu strobes are one cycle
// Notes: buffer index is endpoint for in buffers, endpoint plus five for out
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - five endpoints, each with one in buffer and one out buffer
// - each buffer holds 64 bytes, selected one appears in a data window
// - every buffer has a flag set while the engine owns it
// - cpu reads and writes to an engine-owned buffer are ignored
// - byte count write hands a transmit buffer over until it is sent
// - receive buffer flag sets when the engine starts an out packet
// - end of reception clears the flag and stores the received count
// - enabled buffer whose flag falls raises the interrupt and its flag
// - in token to a transmit buffer not handed over is answered nak
// - endpoints 1 to 4 pair in or out buffers 1+2 and 3+4 only
// - in a pair only the odd endpoint is used by the cpu
// - each byte count update in a pair swaps the active buffer
// - window shows buffers only while visible bit is set
// - window base comes from base high and base low together
// - endpoint select picks endpoint number and direction for the window
// - endpoint select routes control and byte count to f1 and f2
// - setup packet on endpoint 0 stores eight bytes in a setup buffer
// - setup value register returns the byte chosen by setup index
// - control holds enable, stall, toggle and busy; resets to 08
module ufm_endpoint_fifo_manager
	import ufm_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic [15:0] external_data_space_addr_in,
	input wire logic external_data_space_wr_in,
	input wire logic external_data_space_rd_in,
	input wire logic [7:0] external_data_space_wdata_in,
	output logic [7:0] external_data_space_rdata_out,
	input wire logic [2:0] eng_ep_in,
	input wire logic eng_dir_in,
	input wire logic eng_rx_start_in,
	input wire logic eng_rx_done_in,
	input wire logic [6:0] eng_rx_count_in,
	input wire logic eng_tx_done_in,
	input wire logic eng_wr_in,
	input wire logic [5:0] eng_addr_in,
	input wire logic [7:0] eng_wdata_in,
	output logic [7:0] eng_rdata_out,
	output logic eng_nak_out,
	output logic eng_stall_out,
	output logic eng_toggle_out,
	output logic [6:0] eng_size_out,
	input wire logic eng_setup_wr_in,
	input wire logic [2:0] eng_setup_idx_in,
	input wire logic [7:0] eng_setup_data_in,
	input wire logic [9:0] buf_irq_enable_in,
	input wire logic [9:0] buf_flag_clear_in,
	output logic [9:0] buf_flag_out,
	output logic usb_irq_out
);

	// ******************************
	// buffer mapping
	// ******************************
	function automatic logic [1:0] ufm_pair_idx(input logic [2:0] ep,
		input logic dir);
		ufm_pair_idx = {~dir, (ep > 3'd2)};
	endfunction : ufm_pair_idx

	function automatic logic ufm_paired(input logic [2:0] ep,
		input logic dir, input logic [3:0] pair);
		ufm_paired = (ep != 3'd0) && (ep <= 3'd4) &&
			pair[ufm_pair_idx(ep, dir)];
	endfunction : ufm_paired

	// returns {valid, physical buffer index}
	function automatic logic [4:0] ufm_map(input logic [2:0] ep,
		input logic dir, input logic [3:0] pair, input logic [3:0] sel);
		logic [2:0] pe;
		logic [3:0] idx;
		pe = ep;
		if (ufm_paired(ep, dir, pair)) begin
			pe = (ep[0] ? ep : 3'(ep - 3'd1)) +
				{2'b00, sel[ufm_pair_idx(ep, dir)]};
		end
		idx = dir ? {1'b0, pe} : 4'({1'b0, pe} + UFM_OUT_BASE);
		ufm_map = {(ep <= 3'd4), idx};
	endfunction : ufm_map

	ufm_state_s state;
	ufm_state_s next_state;
	logic [7:0] buf_mem [0:UFM_MEM_WORDS-1];

	logic [4:0] cpu_map;
	logic [3:0] cpu_buf;
	logic cpu_ok;
	logic [4:0] eng_map;
	logic [3:0] eng_buf;
	logic win_hit;
	logic cpu_mem_wr;
	logic cpu_mem_rd;
	logic [9:0] cpu_mem_addr;
	logic [9:0] eng_mem_addr;
	logic [1:0] cpu_pidx;
	logic [1:0] eng_pidx;
	logic [9:0] busy_before;
	logic [9:0] busy_after;

	// ******************************
	// cpu and engine decode
	// ******************************
	always_comb begin
		cpu_map = ufm_map(state.sel_ep, state.sel_dir, state.pair,
			state.cpu_sel);
		cpu_buf = cpu_map[3:0];
		// even half of a pair is hidden from the cpu
		cpu_ok = cpu_map[4] && !(ufm_paired(state.sel_ep, state.sel_dir,
			state.pair) && !state.sel_ep[0]);
		eng_map = ufm_map(eng_ep_in, eng_dir_in, state.pair, state.eng_sel);
		eng_buf = eng_map[3:0];
		cpu_pidx = ufm_pair_idx(state.sel_ep, state.sel_dir);
		eng_pidx = ufm_pair_idx(eng_ep_in, eng_dir_in);
		win_hit = state.visible && cpu_ok &&
			(external_data_space_addr_in[15:6] == {state.base_high, state.base_low}) &&
			!state.con[cpu_buf][UFM_CON_BUSY];
		cpu_mem_wr = win_hit && external_data_space_wr_in;
		cpu_mem_rd = win_hit && external_data_space_rd_in;
		cpu_mem_addr = 10'({cpu_buf, 6'h00}) +
			{4'h0, external_data_space_addr_in[5:0]};
		eng_mem_addr = 10'({eng_buf, 6'h00}) + {4'h0, eng_addr_in};
	end

	// ******************************
	// buffer storage
	// ******************************
	// the engine reaches every buffer whatever the visible bit says
	always_ff @(posedge sys_clk_in) begin
		if (cpu_mem_wr) begin
			buf_mem[cpu_mem_addr] <= external_data_space_wdata_in;
		end
		if (eng_wr_in && eng_map[4]) begin
			buf_mem[eng_mem_addr] <= eng_wdata_in;
		end
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			external_data_space_rdata_out <= 8'h00;
			eng_rdata_out <= 8'h00;
		end else begin
			if (cpu_mem_rd) begin
				external_data_space_rdata_out <= buf_mem[cpu_mem_addr];
			end
			if (eng_map[4]) begin
				eng_rdata_out <= buf_mem[eng_mem_addr];
			end
		end
	end

	// ******************************
	// control state
	// ******************************
	always_comb begin
		next_state = state;
		for (int i = 0; i < UFM_NUM_BUF; i++) begin
			busy_before[i] = state.con[i][UFM_CON_BUSY];
		end

		// register writes
		if (sfr_wr_in) begin
			case (sfr_addr_in)
				UFM_ADDR_PAIR: next_state.pair = sfr_wdata_in[3:0];
				UFM_ADDR_CTL: next_state.visible =
					sfr_wdata_in[UFM_CTL_VISIBLE];
				UFM_ADDR_SEL: begin
					next_state.sel_dir = sfr_wdata_in[UFM_SEL_DIR];
					next_state.sel_ep = sfr_wdata_in[2:0];
				end
				UFM_ADDR_CON: begin
					if (cpu_ok) begin
						// busy is owned by hardware and not writable
						next_state.con[cpu_buf][3:1] = sfr_wdata_in[3:1];
					end
				end
				UFM_ADDR_SIZE: begin
					if (cpu_ok && !state.con[cpu_buf][UFM_CON_BUSY]) begin
						next_state.size[cpu_buf] = sfr_wdata_in[6:0];
						if (state.sel_dir) begin
							next_state.con[cpu_buf][UFM_CON_BUSY] = 1'b1;
						end
						if (ufm_paired(state.sel_ep, state.sel_dir,
							state.pair)) begin
							next_state.cpu_sel[cpu_pidx] =
								~state.cpu_sel[cpu_pidx];
						end
					end
				end
				UFM_ADDR_BASEH: next_state.base_high = sfr_wdata_in;
				UFM_ADDR_BASEL: next_state.base_low = sfr_wdata_in[7:6];
				UFM_ADDR_SCI: next_state.setup_idx = sfr_wdata_in[2:0];
				default: begin
				end
			endcase
		end

		// engine events come after the cpu so hardware has the last word
		if (eng_map[4]) begin
			if (eng_rx_start_in && !eng_dir_in) begin
				next_state.con[eng_buf][UFM_CON_BUSY] = 1'b1;
			end
			if (eng_rx_done_in && !eng_dir_in) begin
				next_state.con[eng_buf][UFM_CON_BUSY] = 1'b0;
				next_state.size[eng_buf] = eng_rx_count_in;
			end
			if (eng_tx_done_in && eng_dir_in) begin
				next_state.con[eng_buf][UFM_CON_BUSY] = 1'b0;
			end
			if (eng_rx_done_in || eng_tx_done_in) begin
				next_state.con[eng_buf][UFM_CON_TOGGLE] =
					~state.con[eng_buf][UFM_CON_TOGGLE];
				if (ufm_paired(eng_ep_in, eng_dir_in, state.pair)) begin
					next_state.eng_sel[eng_pidx] =
						~state.eng_sel[eng_pidx];
				end
			end
		end
		if (eng_setup_wr_in) begin
			next_state.setup[eng_setup_idx_in] = eng_setup_data_in;
		end

		// ready flags: a new event beats a clear in the same cycle
		for (int i = 0; i < UFM_NUM_BUF; i++) begin
			busy_after[i] = next_state.con[i][UFM_CON_BUSY];
		end
		next_state.flags = (state.flags & ~buf_flag_clear_in) |
			(busy_before & ~busy_after & buf_irq_enable_in);
		next_state.irq = |next_state.flags;

		// register reads
		if (sfr_rd_in) begin
			case (sfr_addr_in)
				UFM_ADDR_PAIR: next_state.sfr_rdata = {4'h0, state.pair};
				UFM_ADDR_CTL: next_state.sfr_rdata =
					{6'h00, state.visible, 1'b0};
				UFM_ADDR_SEL: next_state.sfr_rdata =
					{state.sel_dir, 4'h0, state.sel_ep};
				UFM_ADDR_CON: next_state.sfr_rdata = cpu_ok ?
					{4'h0, state.con[cpu_buf]} : 8'h00;
				UFM_ADDR_SIZE: next_state.sfr_rdata = cpu_ok ?
					{1'b0, state.size[cpu_buf]} : 8'h00;
				UFM_ADDR_BASEH: next_state.sfr_rdata = state.base_high;
				UFM_ADDR_BASEL: next_state.sfr_rdata =
					{state.base_low, 6'h00};
				UFM_ADDR_SCI: next_state.sfr_rdata =
					{5'h00, state.setup_idx};
				UFM_ADDR_SCV: next_state.sfr_rdata =
					state.setup[state.setup_idx];
				default: next_state.sfr_rdata = 8'h00;
			endcase
		end

		// token answer; an unloaded or disabled buffer is refused
		next_state.eng_nak = !eng_map[4] ||
			!state.con[eng_buf][UFM_CON_BUSY] ||
			!state.con[eng_buf][UFM_CON_ENABLE];
		next_state.eng_stall = eng_map[4] &&
			state.con[eng_buf][UFM_CON_STALL];
		next_state.eng_toggle = eng_map[4] &&
			state.con[eng_buf][UFM_CON_TOGGLE];
		next_state.eng_size = eng_map[4] ? state.size[eng_buf] : 7'h00;
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= '0;
			for (int i = 0; i < UFM_NUM_BUF; i++) begin
				state.con[i] <= UFM_CON_RESET;
			end
			state.eng_nak <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ******************************
	// outputs
	// ******************************
	assign sfr_rdata_out = state.sfr_rdata;
	assign eng_nak_out = state.eng_nak;
	assign eng_stall_out = state.eng_stall;
	assign eng_toggle_out = state.eng_toggle;
	assign eng_size_out = state.eng_size;
	assign buf_flag_out = state.flags;
	assign usb_irq_out = state.irq;

endmodule : ufm_endpoint_fifo_manager

`default_nettype wire

// ---- design/ufm_pkg.sv ----
// Purpose: constants and state layout of the endpoint buffer manager
// Assumes: 8-bit special register bus, 16-bit external data space
// Notes: one packed struct holds all control state of the manager
package ufm_pkg;
	localparam int UFM_NUM_EP = 5;
	localparam int UFM_NUM_BUF = 10;
	localparam int UFM_BUF_BYTES = 64;
	localparam int UFM_MEM_WORDS = UFM_NUM_BUF * UFM_BUF_BYTES;
	localparam int UFM_SETUP_BYTES = 8;

	localparam logic [7:0] UFM_ADDR_PAIR = 8'he3;
	localparam logic [7:0] UFM_ADDR_CTL = 8'hec;
	localparam logic [7:0] UFM_ADDR_SEL = 8'hef;
	localparam logic [7:0] UFM_ADDR_CON = 8'hf1;
	localparam logic [7:0] UFM_ADDR_SIZE = 8'hf2;
	localparam logic [7:0] UFM_ADDR_BASEH = 8'hf3;
	localparam logic [7:0] UFM_ADDR_BASEL = 8'hf4;
	localparam logic [7:0] UFM_ADDR_SCI = 8'hf5;
	localparam logic [7:0] UFM_ADDR_SCV = 8'hf6;

	localparam int UFM_CON_ENABLE = 3;
	localparam int UFM_CON_STALL = 2;
	localparam int UFM_CON_TOGGLE = 1;
	localparam int UFM_CON_BUSY = 0;
	localparam logic [3:0] UFM_CON_RESET = 4'h8;
	localparam int UFM_CTL_VISIBLE = 1;
	localparam int UFM_SEL_DIR = 7;
	localparam logic [3:0] UFM_OUT_BASE = 4'h5;

	typedef struct packed {
		logic [9:0][3:0] con;
		logic [9:0][6:0] size;
		logic [3:0] pair;
		logic sel_dir;
		logic [2:0] sel_ep;
		logic visible;
		logic [7:0] base_high;
		logic [1:0] base_low;
		logic [2:0] setup_idx;
		logic [7:0][7:0] setup;
		logic [3:0] cpu_sel;
		logic [3:0] eng_sel;
		logic [9:0] flags;
		logic irq;
		logic [7:0] sfr_rdata;
		logic eng_nak;
		logic eng_stall;
		logic eng_toggle;
		logic [6:0] eng_size;
	} ufm_state_s;
endpackage : ufm_pkg

// ---- tb/ufm_monitor.sv ----
// Purpose: port checks of the buffer manager
// Assumes: one clock, async reset
// Notes: bound by name
`timescale 1ns/1ns
`default_nettype none
module ufm_monitor (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic external_data_space_rd_in,
	input wire logic [7:0] external_data_space_rdata_out,
	input wire logic [2:0] eng_ep_in,
	input wire logic eng_dir_in,
	input wire logic eng_rx_done_in,
	input wire logic eng_tx_done_in,
	input wire logic eng_nak_out,
	input wire logic [9:0] buf_irq_enable_in,
	input wire logic [9:0] buf_flag_clear_in,
	input wire logic [9:0] buf_flag_out,
	input wire logic usb_irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	irq_tracks_flags_a: assert property (
		usb_irq_out == (|buf_flag_out)) else $error("irq");
	flag_sticky_a: assert property (
		(~buf_flag_out & $past(buf_flag_out) & ~$past(buf_flag_clear_in))
		== 10'h000) else $error("flag lost");
	flag_gated_a: assert property (
		(buf_flag_out & ~$past(buf_flag_out) & ~$past(buf_irq_enable_in))
		== 10'h000) else $error("flag masked");
	send_nak_a: assert property (
		eng_tx_done_in && eng_dir_in && eng_ep_in == 3'h0 ##1 eng_dir_in
		&& eng_ep_in == 3'h0 |-> ##[1:2] eng_nak_out) else $error("nak");
	tx_flag_a: assert property (
		eng_tx_done_in && eng_dir_in && eng_ep_in == 3'h0 &&
		buf_irq_enable_in[0] |-> ##[1:3] buf_flag_out[0]) else $error("tx");
	rx_flag_a: assert property (
		eng_rx_done_in && !eng_dir_in && eng_ep_in == 3'h0 &&
		buf_irq_enable_in[5] |-> ##[1:3] buf_flag_out[5]) else $error("rx");
	window_hold_a: assert property (
		!$past(external_data_space_rd_in) |-> $stable(external_data_space_rdata_out)) else $error("win");
	reg_hold_a: assert property (
		!$past(sfr_rd_in) |-> $stable(sfr_rdata_out)) else $error("reg");
endmodule : ufm_monitor
bind ufm_endpoint_fifo_manager ufm_monitor mon (.*);
`default_nettype wire

// ---- tb/ufm_engine_model.sv ----
// Purpose: behavioural serial engine
// Assumes: moves on the falling edge
// Notes: ports named after the pins they meet
`timescale 1ns/1ns
`default_nettype none
module ufm_engine_model (
	input wire logic sys_clk_in,
	input wire logic eng_nak_out,
	input wire logic [7:0] eng_rdata_out,
	output logic [2:0] eng_ep_in = '0,
	output logic eng_dir_in = '0,
	output logic eng_rx_start_in = '0,
	output logic eng_rx_done_in = '0,
	output logic [6:0] eng_rx_count_in = '0,
	output logic eng_tx_done_in = '0,
	output logic eng_wr_in = '0,
	output logic [5:0] eng_addr_in = '0,
	output logic [7:0] eng_wdata_in = '0,
	output logic eng_setup_wr_in = '0,
	output logic [2:0] eng_setup_idx_in = '0,
	output logic [7:0] eng_setup_data_in = '0
);
	// out packet; each byte also writes the setup buffer at index i mod 8
	task automatic rx(input logic [2:0] ep, input logic [6:0] n);
		@(negedge sys_clk_in);
		{eng_ep_in, eng_dir_in, eng_rx_start_in} = {ep, 2'h1};
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk_in);
			{eng_rx_start_in, eng_wr_in, eng_setup_wr_in} = 3'h3;
			{eng_addr_in, eng_setup_idx_in} = {6'(i), 3'(i)};
			eng_wdata_in = 8'h30 + 8'(i);
			eng_setup_data_in = 8'ha0 + 8'(i);
		end
		@(negedge sys_clk_in);
		{eng_wr_in, eng_setup_wr_in, eng_rx_done_in} = 3'h1;
		eng_rx_count_in = n;
		{eng_wdata_in, eng_setup_data_in} = ~{eng_wdata_in, eng_setup_data_in};
		@(negedge sys_clk_in);
		eng_rx_done_in = 1'h0;
	endtask : rx
	// in token: sends only when the buffer was handed over
	task automatic tx(input logic [2:0] ep, output logic nak,
			output logic [7:0] b0);
		@(negedge sys_clk_in);
		{eng_ep_in, eng_dir_in, eng_addr_in} = {ep, 1'h1, 6'h00};
		repeat (2) @(negedge sys_clk_in);
		{nak, b0} = {eng_nak_out, eng_rdata_out};
		if (!nak) begin
			eng_tx_done_in = 1'h1;
			@(negedge sys_clk_in);
			eng_tx_done_in = 1'h0;
		end
	endtask : tx
endmodule : ufm_engine_model
`default_nettype wire

// ---- tb/ufm_endpoint_fifo_manager_tb.sv ----
// Purpose: directed test of the buffer manager
// Assumes: engine model drives the engine pins
// Notes: window base 1240h
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %0t %h %h", $time, (g), (e)); end end
module ufm_endpoint_fifo_manager_tb
	import ufm_pkg::*;
;
	localparam logic SFR = 1'h0, WIN = 1'h1, WR = 1'h1, RD = 1'h0;
	logic sys_clk_in = 1'h0, reset_in = 1'h1, nak;
	logic sfr_wr_in = '0, sfr_rd_in = '0, external_data_space_wr_in = '0, external_data_space_rd_in = '0;
	logic [7:0] sfr_addr_in = '0, sfr_wdata_in = '0, external_data_space_wdata_in = '0;
	logic [15:0] external_data_space_addr_in = '0;
	logic [9:0] buf_irq_enable_in = 10'h3ff, buf_flag_clear_in = '0;
	logic [9:0] buf_flag_out;
	logic [7:0] sfr_rdata_out, external_data_space_rdata_out, eng_rdata_out, b;
	logic [7:0] eng_wdata_in, eng_setup_data_in;
	logic [6:0] eng_rx_count_in, eng_size_out;
	logic [5:0] eng_addr_in;
	logic [2:0] eng_ep_in, eng_setup_idx_in;
	logic eng_dir_in, eng_rx_start_in, eng_rx_done_in, eng_tx_done_in;
	logic eng_wr_in, eng_setup_wr_in, eng_nak_out, eng_stall_out;
	logic eng_toggle_out, usb_irq_out;
	int err_total = 0, n_checks = 0;
	ufm_endpoint_fifo_manager uut (.*);
	ufm_engine_model eng (.*);
	always #50 sys_clk_in = ~sys_clk_in;
	// reads compare against d, writes store d
	task automatic op(input logic x, w, input logic [7:0] a, d);
		@(negedge sys_clk_in);
		{sfr_addr_in, sfr_wdata_in, external_data_space_wdata_in} = {a, d, d};
		external_data_space_addr_in = 16'h1240 + 16'(a);
		{sfr_wr_in, sfr_rd_in} = {!x & w, !x & !w};
		{external_data_space_wr_in, external_data_space_rd_in} = {x & w, x & !w};
		@(negedge sys_clk_in);
		{sfr_wr_in, sfr_rd_in, external_data_space_wr_in, external_data_space_rd_in} = 4'h0;
		if (!w) `CHK(x ? external_data_space_rdata_out : sfr_rdata_out, d)
	endtask : op
	task automatic stop_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (12) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		reset_in = 1'h0;
		op(SFR, RD, UFM_ADDR_CON, 8'h08);
		op(SFR, RD, 8'h00, 8'h00);
		op(SFR, WR, UFM_ADDR_BASEH, 8'h12);
		op(SFR, WR, UFM_ADDR_BASEL, 8'h40);
		op(SFR, WR, UFM_ADDR_CTL, 8'h02);
		op(SFR, WR, UFM_ADDR_SEL, 8'h80);
		op(WIN, WR, 8'h00, 8'h11);
		op(WIN, WR, 8'h3f, 8'h22);
		op(WIN, RD, 8'h00, 8'h11);
		op(WIN, RD, 8'h3f, 8'h22);
		eng.tx(3'h0, nak, b);
		`CHK(nak, 1'h1)
		op(SFR, WR, UFM_ADDR_SIZE, 8'h02);
		op(SFR, RD, UFM_ADDR_CON, 8'h09);
		op(WIN, WR, 8'h00, 8'hee);
		eng.tx(3'h0, nak, b);
		`CHK({nak, b}, 9'h011)
		repeat (3) @(negedge sys_clk_in);
		`CHK({usb_irq_out, buf_flag_out}, 11'h401)
		`CHK({eng_toggle_out, eng_stall_out, eng_size_out}, 9'h102)
		// a one-cycle clear drops the flag and the interrupt with it
		buf_flag_clear_in = 10'h001;
		@(negedge sys_clk_in);
		buf_flag_clear_in = '0;
		`CHK({usb_irq_out, buf_flag_out}, 11'h000)
		op(SFR, RD, UFM_ADDR_CON, 8'h0a);
		op(SFR, WR, UFM_ADDR_CON, 8'h0d);
		op(SFR, RD, UFM_ADDR_CON, 8'h0c);
		`CHK({eng_toggle_out, eng_stall_out}, 2'h1)
		op(WIN, RD, 8'h00, 8'h11);
		op(SFR, WR, UFM_ADDR_CTL, 8'h00);
		op(WIN, RD, 8'h3f, 8'h11);
		op(SFR, WR, UFM_ADDR_CTL, 8'h02);
		eng.rx(3'h0, 7'h08);
		op(SFR, WR, UFM_ADDR_SEL, 8'h00);
		op(SFR, RD, UFM_ADDR_SIZE, 8'h08);
		op(WIN, RD, 8'h04, 8'h34);
		`CHK(buf_flag_out[5], 1'h1)
		for (int i = 0; i < 8; i++) begin
			op(SFR, WR, UFM_ADDR_SCI, 8'(i));
			op(SFR, RD, UFM_ADDR_SCV, 8'ha0 + 8'(i));
		end
		op(SFR, WR, UFM_ADDR_PAIR, 8'h01);
		op(SFR, WR, UFM_ADDR_SEL, 8'h81);
		op(WIN, WR, 8'h00, 8'h55);
		op(SFR, WR, UFM_ADDR_SIZE, 8'h01);
		op(WIN, WR, 8'h00, 8'h66);
		op(SFR, WR, UFM_ADDR_SIZE, 8'h01);
		// first half of the pair is masked, second half is not
		buf_irq_enable_in = 10'h3fd;
		eng.tx(3'h1, nak, b);
		`CHK({nak, b}, 9'h055)
		eng.tx(3'h1, nak, b);
		`CHK({nak, b}, 9'h066)
		`CHK(buf_flag_out, 10'h024)
		op(SFR, WR, UFM_ADDR_SEL, 8'h82);
		op(SFR, RD, UFM_ADDR_CON, 8'h00);
		stop_test();
	end
endmodule : ufm_endpoint_fifo_manager_tb
`default_nettype wire
